/* rtl/mux_sample_hold_sequencer.sv */
`timescale 1ns/1ps
`include "mux_ctrl_map.svh"
module mux_sample_hold_sequencer #(
    parameter int DATA_W      = 12,
    parameter bit CONT_SAMPLE = 1'b0
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  ce_i,
    input  wire logic                  req_valid_i,
    input  mux_ctrl_pkg::req_type      req_i,
    output logic                       req_ready_o,
    input  wire logic                  adc_status_i,
    input  wire logic [DATA_W-1:0]     adc_data_i,
    output mux_ctrl_pkg::pins_type     pins_o,
    output logic                       hold_cmd_o,
    output logic                       convert_start_o,
    output logic                       result_valid_o,
    output logic [DATA_W-1:0]          result_data_o,
    output mux_ctrl_pkg::req_type      result_req_o,
    output logic                       error_o
);
    import mux_ctrl_pkg::*;

    localparam int TW = `TIMER_W;

    // Bad data widths, and settle or acquisition counts the timer cannot hold, are refused.
    if (DATA_W < 1 || DATA_W > 32) begin : g_bad_width
        $error("DATA_W must lie between 1 and 32");
    end
    if (`ACQ_CYC >= (1 << TW) || `SETTLE_CYC >= (1 << TW)) begin : g_bad_timer
        $error("Interval counts exceed the timer width");
    end

    state_type         state_q;
    state_type         state_d;
    pins_type          pins_q;
    req_type           cur_q;
    req_type           next_q;
    logic              pend_q;
    logic              seen_q;
    logic              hold_q;
    logic              conv_q;
    logic              ready_q;
    logic              res_valid_q;
    logic [DATA_W-1:0] res_data_q;
    req_type           res_req_q;
    logic              err_q;
    logic [TW-1:0]     pre_cnt_q;
    logic              status_meta_q;
    logic              status_sync_q;
    logic [DATA_W-1:0] data_meta_q;
    logic [DATA_W-1:0] data_sync_q;
    logic              t_load;
    logic [TW-1:0]     t_val;
    logic              t_expired;
    logic              accept;
    logic              status_fall;
    logic              timeout;

    // Differential orders force the extension bit high; pairs use the low bits.
    function automatic pins_type drive_addr(input req_type r, input logic latch);
        pins_type p;
        p.address_extend_bit = r.diff | r.channel[`ADDR_EXT_POS];
        p.addr_bit_two       = r.channel[`ADDR_TWO_POS];
        p.addr_bit_one       = r.channel[`ADDR_ONE_POS];
        p.addr_bit_zero      = r.channel[`ADDR_ZERO_POS];
        p.latch_ctrl         = latch;
        p.diff_mode          = r.diff;
        return p;
    endfunction

    // Timer load value for a wait of n cycles; the counter shows expiry one load later.
    function automatic logic [TW-1:0] cyc(input int n);
        return TW'(n - 1);
    endfunction

    interval_timer #(
        .W (TW)
    ) u_timer (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .load_i    (t_load),
        .value_i   (t_val),
        .expired_o (t_expired)
    );

    // Status and data come from the converter's clock-free pins.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_meta_q <= 1'b0;
            status_sync_q <= 1'b0;
            data_meta_q   <= '0;
            data_sync_q   <= '0;
        end else if (ce_i) begin
            status_meta_q <= adc_status_i;
            status_sync_q <= status_meta_q;
            data_meta_q   <= adc_data_i;
            data_sync_q   <= data_meta_q;
        end
    end

    // Handshake and converter status terms; status is only trusted once seen high.
    assign accept      = req_valid_i & ready_q;
    assign status_fall = (state_q == S_CONV) & seen_q & ~status_sync_q;
    assign timeout     = (state_q == S_CONV) & ~seen_q & ~status_sync_q & t_expired;

    // Sequencer: latch, settle, start, convert, release, acquire.
    always_comb begin
        state_d = state_q;
        t_load  = 1'b0;
        t_val   = '0;
        case (state_q)
            S_IDLE: begin
                if (accept) begin
                    state_d = S_LOAD;
                    t_load  = 1'b1;
                    t_val   = cyc(`LATCH_CYC);
                end
            end
            S_LOAD: begin
                if (t_expired) begin
                    state_d = S_SETTLE;
                    t_load  = 1'b1;
                    t_val   = cyc(`SETTLE_CYC);
                end
            end
            S_SETTLE: begin
                if (t_expired) begin
                    state_d = S_START;
                    t_load  = 1'b1;
                    t_val   = cyc(`CONV_PULSE_CYC);
                end
            end
            S_START: begin
                if (t_expired) begin
                    state_d = S_CONV;
                    t_load  = 1'b1;
                    t_val   = cyc(`START_TIMEOUT_CYC);
                end
            end
            S_CONV: begin
                if (status_fall) begin
                    state_d = S_RELEASE;
                    t_load  = 1'b1;
                    t_val   = cyc(`RELEASE_CYC);
                end else if (timeout) begin
                    state_d = S_IDLE;
                end
            end
            S_RELEASE: begin
                if (t_expired) begin
                    state_d = S_ACQ;
                    t_load  = 1'b1;
                    t_val   = cyc(`ACQ_CYC);
                end
            end
            S_ACQ: begin
                if (t_expired && pre_cnt_q == '0) begin
                    // A prefetched address settled during the hold, so go straight on.
                    state_d = pend_q ? S_START : S_IDLE;
                    t_load  = pend_q;
                    t_val   = cyc(`CONV_PULSE_CYC);
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= S_IDLE;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    // Orders are taken when idle, or once the converter is seen busy.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ready_q <= 1'b0;
        end else if (ce_i) begin
            ready_q <= (state_d == S_IDLE) ||
                       (state_d == S_CONV && state_q == S_CONV &&
                        (seen_q | status_sync_q) && !(pend_q | accept));
        end
    end

    // Pins change only together with a rising latch, so they are steady at its fall.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pins_q    <= '0;
            cur_q     <= '0;
            next_q    <= '0;
            pend_q    <= 1'b0;
            pre_cnt_q <= '0;
        end else if (ce_i) begin
            if (accept && state_q == S_IDLE) begin
                pins_q <= drive_addr(req_i, 1'b1);
                cur_q  <= req_i;
            end else if (accept) begin
                pins_q    <= drive_addr(req_i, 1'b1);
                next_q    <= req_i;
                pend_q    <= 1'b1;
                pre_cnt_q <= TW'(`LATCH_CYC);
            end else if (state_q == S_LOAD && t_expired) begin
                pins_q.latch_ctrl <= 1'b0;
            end else if (pre_cnt_q == TW'(1)) begin
                pins_q.latch_ctrl <= 1'b0;
                pre_cnt_q         <= '0;
            end else if (pre_cnt_q != '0) begin
                pre_cnt_q <= pre_cnt_q - 1'b1;
            end
            if (state_q == S_ACQ && state_d == S_START) begin
                cur_q  <= next_q;
                pend_q <= 1'b0;
            end
        end
    end

    // Convert pulse, and hold raised with it so the sample is frozen at once.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conv_q <= 1'b0;
            hold_q <= 1'b0;
            seen_q <= 1'b0;
        end else if (ce_i) begin
            conv_q <= (state_d == S_START);
            if (state_d == S_START && state_q != S_START) begin
                hold_q <= ~CONT_SAMPLE;
            end else if ((state_q == S_RELEASE && t_expired) || timeout) begin
                hold_q <= 1'b0;
            end
            if (state_q != S_CONV) begin
                seen_q <= 1'b0;
            end else if (status_sync_q) begin
                seen_q <= 1'b1;
            end
        end
    end

    // Data is taken after the release delay, when the last bit has surely settled.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            res_valid_q <= 1'b0;
            res_data_q  <= '0;
            res_req_q   <= '0;
            err_q       <= 1'b0;
        end else if (ce_i) begin
            res_valid_q <= (state_q == S_RELEASE) && t_expired;
            err_q       <= timeout;
            if (state_q == S_RELEASE && t_expired) begin
                res_data_q <= data_sync_q;
                res_req_q  <= cur_q;
            end
        end
    end

    assign req_ready_o     = ready_q;
    assign pins_o          = pins_q;
    assign hold_cmd_o      = hold_q;
    assign convert_start_o = conv_q;
    assign result_valid_o  = res_valid_q;
    assign result_data_o   = res_data_q;
    assign result_req_o    = res_req_q;
    assign error_o         = err_q;

    // Helper counters: cycles since an address change and since return to sample.
    logic [TW-1:0] since_chg_q;
    logic [TW-1:0] since_rel_q;
    logic          chg_in_hold_q;
    logic [4:0]    prev_addr_q;
    logic [4:0]    cur_addr;
    assign cur_addr = {pins_q.address_extend_bit, pins_q.addr_bit_two,
                       pins_q.addr_bit_one, pins_q.addr_bit_zero, pins_q.diff_mode};

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            since_chg_q   <= '1;
            since_rel_q   <= '1;
            chg_in_hold_q <= 1'b0;
            prev_addr_q   <= '0;
        end else if (ce_i) begin
            prev_addr_q <= cur_addr;
            if (cur_addr != prev_addr_q) begin
                since_chg_q   <= '0;
                chg_in_hold_q <= hold_q;
            end else if (since_chg_q != '1) begin
                since_chg_q <= since_chg_q + 1'b1;
            end
            if (hold_q) begin
                since_rel_q <= '0;
            end else if (since_rel_q != '1) begin
                since_rel_q <= since_rel_q + 1'b1;
            end
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i || !ce_i);

    sequence s_start;
        $rose(convert_start_o);
    endsequence
    sequence s_end_of_conv;
        state_q == S_CONV && seen_q && !status_sync_q;
    endsequence

    property p_pulse;
        s_start |-> convert_start_o [*8] ##1 !convert_start_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("Convert pulse width wrong");

    property p_hold_with_start;
        s_start |-> (hold_cmd_o != CONT_SAMPLE);
    endproperty
    a_hold_with_start: assert property (p_hold_with_start) else $error("Hold not set");

    property p_cont;
        hold_cmd_o |-> !CONT_SAMPLE &&
            (state_q == S_START || state_q == S_CONV || state_q == S_RELEASE);
    endproperty
    a_cont: assert property (p_cont) else $error("Hold raised in sampling mode");

    property p_settle;
        s_start |-> chg_in_hold_q || since_chg_q >= TW'(`SETTLE_CYC);
    endproperty
    a_settle: assert property (p_settle) else $error("Start before settling");

    property p_acq;
        s_start |-> since_rel_q >= TW'(`ACQ_CYC);
    endproperty
    a_acq: assert property (p_acq) else $error("Start before acquisition");

    property p_release;
        s_end_of_conv ##0 !CONT_SAMPLE |-> hold_cmd_o [*3] ##1 !hold_cmd_o && result_valid_o;
    endproperty
    a_release: assert property (p_release) else $error("Hold release timing wrong");

    property p_overlap;
        $rose(pins_o.latch_ctrl) |-> $past(state_q) == S_IDLE || hold_cmd_o;
    endproperty
    a_overlap: assert property (p_overlap) else $error("Address changed outside hold");

    property p_latch_fall;
        $fell(pins_o.latch_ctrl) |-> $stable(cur_addr);
    endproperty
    a_latch_fall: assert property (p_latch_fall) else $error("Address moved at latch");

    property p_diff_ext;
        pins_o.diff_mode |-> pins_o.address_extend_bit;
    endproperty
    a_diff_ext: assert property (p_diff_ext) else $error("Extension bit low in pairs");

endmodule // mux_sample_hold_sequencer

/* shared/mux_ctrl_map.svh */
`ifndef MUX_CTRL_MAP_SVH
`define MUX_CTRL_MAP_SVH

// Clock rate of ref_clk_i in MHz.
`define CLK_MHZ            200
// Width of every interval counter.
`define TIMER_W            12

// Address bit positions on the channel select pins.
`define ADDR_EXT_POS       3
`define ADDR_TWO_POS       2
`define ADDR_ONE_POS       1
`define ADDR_ZERO_POS      0

// Intervals in ns as they are specified.
`define SETTLE_NS          6000
`define ACQ_NS             10000
`define LATCH_NS           50
`define CONV_PULSE_NS      40
`define RELEASE_NS         10
`define START_TIMEOUT_NS   5000

// Least times round up, the longest wait rounds down.
`define SETTLE_CYC         ((`SETTLE_NS * `CLK_MHZ + 999) / 1000)
`define ACQ_CYC            ((`ACQ_NS * `CLK_MHZ + 999) / 1000)
`define LATCH_CYC          ((`LATCH_NS * `CLK_MHZ + 999) / 1000)
`define CONV_PULSE_CYC     ((`CONV_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define RELEASE_CYC        ((`RELEASE_NS * `CLK_MHZ + 999) / 1000)
`define START_TIMEOUT_CYC  ((`START_TIMEOUT_NS * `CLK_MHZ) / 1000)

`endif

/* shared/mux_ctrl_pkg.sv */
package mux_ctrl_pkg;

    // Sequencer states, Gray coded along the conversion path.
    typedef enum logic [2:0] {
        S_IDLE    = 3'h0,
        S_LOAD    = 3'h1,
        S_SETTLE  = 3'h3,
        S_START   = 3'h2,
        S_CONV    = 3'h6,
        S_RELEASE = 3'h7,
        S_ACQ     = 3'h5
    } state_type;

    // One conversion order: mode and channel or pair number.
    typedef struct packed {
        logic       diff;
        logic [3:0] channel;
    } req_type;

    // Digital pins that face the multiplexer front end.
    typedef struct packed {
        logic address_extend_bit;
        logic addr_bit_two;
        logic addr_bit_one;
        logic addr_bit_zero;
        logic latch_ctrl;
        logic diff_mode;
    } pins_type;

endpackage

/* rtl/interval_timer.sv */
`timescale 1ns/1ps
module interval_timer #(
    parameter int W = 12
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         ce_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    output logic              expired_o
);

    logic [W-1:0] count_q;

    // Down counter; a load of N shows expiry N cycles later.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_q <= '0;
        end else if (ce_i) begin
            if (load_i) begin
                count_q <= value_i;
            end else if (count_q != '0) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    // Expiry is a level so the sequencer may wait on other terms as well.
    assign expired_o = (count_q == '0);

endmodule // interval_timer

/* verif/mux_device_model.sv */
`timescale 1ns/1ps
`include "mux_ctrl_map.svh"
module mux_device_model (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_b_i,
    input  mux_ctrl_pkg::pins_type pins_i,
    input  wire logic              hold_cmd_i,
    input  wire logic              convert_start_i,
    input  wire logic              answer_i,
    input  wire logic [9:0]        conv_len_i,
    output logic                   adc_status_o,
    output logic [11:0]            adc_data_o,
    output logic [7:0]             viol_o
);
    import mux_ctrl_pkg::*;
    logic [3:0]  pin_addr;
    logic [3:0]  addr_q;
    logic [3:0]  eff_addr;
    logic [3:0]  prev_pin_q;
    logic [4:0]  prev_sel_q;
    logic [11:0] live_val;
    logic [11:0] held_q;
    logic        prev_start_q;
    logic        prev_hold_q;
    logic        prev_latch_q;
    int          settle_cnt;
    int          acq_cnt;
    int          conv_cnt;

    // The extension pin is the most significant address bit.
    assign pin_addr = {pins_i.address_extend_bit, pins_i.addr_bit_two,
                       pins_i.addr_bit_one, pins_i.addr_bit_zero};
    // The latch passes the pins while its control is high and keeps the last value.
    assign eff_addr = pins_i.latch_ctrl ? pin_addr : addr_q;

    // Storage half of the transparent latch, frozen by the falling control.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_q <= 4'h0;
        end else if (pins_i.latch_ctrl) begin
            addr_q <= pin_addr;
        end
    end

    // Each input reads as a distinct level; a pair without the extension bit reads as junk.
    always_comb begin
        if (!pins_i.diff_mode) begin
            live_val = {8'h10, eff_addr};
        end else begin
            live_val = eff_addr[3] ? {9'h040, eff_addr[2:0]} : 12'h0ee;
        end
    end

    // The held level follows the input only while the hold command is low.
    always_ff @(posedge ref_clk_i) begin
        if (!hold_cmd_i) begin
            held_q <= live_val;
        end
    end

    // Converter and timing watch; counters start at 1 so a full interval reads exactly.
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            adc_status_o <= 1'b0;
            adc_data_o   <= 12'h000;
            viol_o       <= 8'h00;
            conv_cnt     <= 0;
            settle_cnt   <= 0;
            acq_cnt      <= 65535;
            prev_start_q <= 1'b0;
            prev_hold_q  <= 1'b0;
            prev_latch_q <= 1'b0;
            prev_pin_q   <= 4'h0;
            prev_sel_q   <= 5'h00;
        end else begin
            prev_start_q <= convert_start_i;
            prev_hold_q  <= hold_cmd_i;
            prev_latch_q <= pins_i.latch_ctrl;
            prev_pin_q   <= pin_addr;
            prev_sel_q   <= {pins_i.diff_mode, eff_addr};
            if ({pins_i.diff_mode, eff_addr} != prev_sel_q && !hold_cmd_i) begin
                settle_cnt <= 1;
            end else if (settle_cnt < 65535) begin
                settle_cnt <= settle_cnt + 1;
            end
            if (prev_hold_q && !hold_cmd_i) begin
                acq_cnt <= 1;
            end else if (acq_cnt < 65535) begin
                acq_cnt <= acq_cnt + 1;
            end
            if (prev_latch_q && !pins_i.latch_ctrl && pin_addr != prev_pin_q) begin
                viol_o <= viol_o + 8'h01;
            end
            if (convert_start_i && !prev_start_q) begin
                if (settle_cnt < `SETTLE_CYC || acq_cnt < `ACQ_CYC) begin
                    viol_o <= viol_o + 8'h01;
                end
                adc_status_o <= answer_i;
                conv_cnt     <= int'(conv_len_i);
            end else if (adc_status_o) begin
                if (!hold_cmd_i) begin
                    viol_o <= viol_o + 8'h01;
                end
                // Data is put out before status falls, so the falling edge finds it valid.
                if (conv_cnt == 1) begin
                    adc_data_o <= held_q;
                end
                if (conv_cnt == 0) begin
                    adc_status_o <= 1'b0;
                end
                conv_cnt <= conv_cnt - 1;
            end
        end
    end
endmodule // mux_device_model

/* verif/test_mux_sample_hold_sequencer.sv */
`timescale 1ns/1ps
module test_mux_sample_hold_sequencer;
    import mux_ctrl_pkg::*;
    logic        ref_clk_i, rst_b_i, ce, req_valid, ready, status, hold;
    logic        cstart, rvalid, err, answer;
    req_type     req, rreq;
    pins_type    pins, pins_seen;
    logic [11:0] adc_data, rdata;
    logic [9:0]  conv_len;
    logic [7:0]  viol;
    int          miscompares, checks;

    mux_sample_hold_sequencer uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
        .req_valid_i(req_valid), .req_i(req), .req_ready_o(ready), .adc_status_i(status),
        .adc_data_i(adc_data), .pins_o(pins), .hold_cmd_o(hold), .convert_start_o(cstart),
        .result_valid_o(rvalid), .result_data_o(rdata), .result_req_o(rreq), .error_o(err));

    mux_device_model dev (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .pins_i(pins),
        .hold_cmd_i(hold), .convert_start_i(cstart), .answer_i(answer),
        .conv_len_i(conv_len), .adc_status_o(status), .adc_data_o(adc_data), .viol_o(viol));

    // Free running 200 MHz clock.
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // One comparison; an unknown seen value counts as a mismatch.
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // The single place where the run ends, with the counts and the verdict.
    task automatic report_and_stop;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Level that the front end shows for a channel or a pair.
    function automatic logic [11:0] exp_val(input logic d, input logic [3:0] c);
        return d ? {9'h040, c[2:0]} : {8'h10, c};
    endfunction

    // Offer an order and hold it until ready has been seen high at an edge.
    task automatic send(input logic d, input logic [3:0] c);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        req       = '{d, c};
        req_valid = 1'b1;
        while (ready !== 1'b1 && n < 8000) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n == 8000) miscompares++;
        @(negedge ref_clk_i);
        req_valid = 1'b0;
    endtask

    // Wait for a result pulse and compare it with the ordered channel.
    task automatic get_result(input logic d, input logic [3:0] c);
        int n;
        n = 0;
        while (rvalid !== 1'b1 && n < 9000) begin
            @(negedge ref_clk_i);
            n++;
        end
        check("result_valid", 16'(rvalid), 16'h0001);
        check("result_data", 16'(rdata), 16'(exp_val(d, c)));
        check("result_req", 16'(rreq), 16'({d, c}));
        check("hold_cmd", 16'(hold), 16'h0000);
        @(negedge ref_clk_i);
        check("result_pulse", 16'(rvalid), 16'h0000);
    endtask

    // Main sequence: reset, clock enable freeze, full sweep, converter that never answers.
    initial begin
        int n;
        ce = 1'b1;
        req_valid = 1'b0;
        req = '0;
        rst_b_i = 1'b0;
        answer = 1'b1;
        conv_len = 10'd20;
        miscompares = 0;
        checks = 0;
        n = 0;
        repeat (4) @(negedge ref_clk_i);
        check("pins_reset", 16'(pins), 16'h0000);
        check("ready_reset", 16'(ready), 16'h0000);
        check("hold_reset", 16'(hold), 16'h0000);
        rst_b_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        check("ready_idle", 16'(ready), 16'h0001);
        send(1'b0, 4'h3);
        ce = 1'b0;
        pins_seen = pins;
        repeat (40) @(negedge ref_clk_i);
        check("pins_frozen", 16'(pins), 16'(pins_seen));
        ce = 1'b1;
        // Latch pulse counting was frozen, so it still stands eight cycles after resuming.
        repeat (8) @(negedge ref_clk_i);
        check("latch_resumed", 16'(pins.latch_ctrl), 16'h0001);
        get_result(1'b0, 4'h3);
        // Every single channel then every pair; each order after the first is offered during the last one.
        for (int i = 0; i < 24; i++) begin
            conv_len = i[0] ? 10'd300 : 10'd20;
            send(i >= 16, 4'(i));
            if (i > 0) get_result(i > 16, 4'(i - 1));
        end
        get_result(1'b1, 4'h7);
        answer = 1'b0;
        send(1'b0, 4'h9);
        while (err !== 1'b1 && n < 4000) begin
            @(negedge ref_clk_i);
            n++;
        end
        check("error", 16'(err), 16'h0001);
        @(negedge ref_clk_i);
        check("hold_after_error", 16'(hold), 16'h0000);
        answer = 1'b1;
        check("violations", 16'(viol), 16'h0000);
        report_and_stop;
    end

    // A hung handshake ends the run as a failure.
    initial begin
        repeat (90000) @(posedge ref_clk_i);
        miscompares++;
        report_and_stop;
    end
endmodule // test_mux_sample_hold_sequencer
